// >>> tupe_match_modify.sv
/*
 * qualification of one table entry and computation of its new port mask.
 * assumes a registered entry and stable configuration at its inputs.
 */
`timescale 1ns/100ps
`default_nettype none
module tupe_match_modify
   import vlan_tupe_pkg::*;
(
   // configuration and entry under test
   input  wire tupeCfg_t   cfg,
   input  wire vlanEntry_t entry,
   // result
   output logic            qualifies,
   output logic [PORTS-1:0] newPorts
);

   function automatic logic overlap53(input logic [PORTS-1:0] a, input logic [PORTS-1:0] b);
      overlap53 = |(a & b);
   endfunction : overlap53

   wire grpHit  = |(entry.grp & cfg.bitMask);
   wire valOk   = !cfg.valEna || ((entry.grp & cfg.valMask) == cfg.reqVal);
   wire bitOk   = !cfg.bitEna || grpHit;
   wire aOk     = !cfg.aEna || overlap53(entry.ports, cfg.filtA);
   wire bOk     = !cfg.bEna || overlap53(entry.ports, cfg.filtB);
   wire combOk  = !cfg.combEna || grpHit || overlap53(entry.ports, cfg.filtA);

   assign qualifies = valOk && bitOk && aOk && bOk && combOk;

   genvar p;
   generate
      for (p = 0; p < PORTS; p++) begin : g_port
         assign newPorts[p] = (cfg.clr[p] && cfg.set[p]) ? !entry.ports[p] :
                              cfg.clr[p] ? 1'b0 :
                              cfg.set[p] ? 1'b1 : entry.ports[p];
      end
   endgenerate

endmodule : tupe_match_modify
`default_nettype wire

// >>> vlan_table_bulk_updater.sv
/*
 * apb register file and read-modify-write walker of the vlan table bulk updater.
 * assumes the table arbiter grants with tabGnt and returns read data with a
 * one-cycle tabRvalid pulse, all on clk.
 */
// The register offsets and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module vlan_table_bulk_updater
   import vlan_tupe_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // vlan table port
   output tableReq_t        tabReq,
   input  wire logic        tabGnt,
   input  wire logic        tabRvalid,
   input  wire vlanEntry_t  tabRdata
);

   // ***********************************************
   // register file
   // ***********************************************
   typedef enum {ST_IDLE, ST_READ, ST_WAIT, ST_EVAL, ST_WRITE} engState_t;

   logic [MISC_W-1:0] misc_ff;
   logic [ADDR_W-1:0] first_ff;
   logic [ADDR_W-1:0] last_ff;
   logic [PORTS-1:0]  clr_ff;
   logic [PORTS-1:0]  set_ff;
   logic [GRP_W-1:0]  reqVal_ff;
   logic [GRP_W-1:0]  valMask_ff;
   logic [GRP_W-1:0]  bitMask_ff;
   logic [PORTS-1:0]  filtA_ff;
   logic [PORTS-1:0]  filtB_ff;
   logic              pready_ff;
   logic              pslverr_ff;
   logic [31:0]       prdata_ff;
   engState_t         state_ff;
   engState_t         nxt_state;
   logic [ADDR_W-1:0] addr_ff;
   logic [ADDR_W-1:0] nxt_addr;
   logic              launch_ff;
   logic              nxt_launch;
   vlanEntry_t        entry_ff;
   vlanEntry_t        nxt_entry;
   tableReq_t         req_ff;
   tableReq_t         nxt_req;
   logic              qualifies;
   logic [PORTS-1:0]  newPorts;

   function automatic logic [PORTS-1:0] merge53(input logic [PORTS-1:0] old,
                                                input logic [31:0] d,
                                                input logic hi);
      merge53 = hi ? {d[HI_W-1:0], old[31:0]} : {old[PORTS-1:32], d};
   endfunction : merge53

   function automatic logic [31:0] hiWord(input logic [PORTS-1:0] v);
      hiWord = {{(32-HI_W){1'b0}}, v[PORTS-1:32]};
   endfunction : hiWord

   wire [7:0] offs    = paddr[7:0];
   wire       mapped  = (paddr[31:8] == 24'h0) && (offs <= OFF_FB_HI) && (offs[1:0] == 2'b00);
   wire       setup   = psel && !penable && !pready_ff;
   wire       wrEn    = psel && penable && pready_ff && pwrite && mapped;
   wire       wrMisc  = wrEn && offs == OFF_MISC;
   wire       wrRange = wrEn && offs == OFF_RANGE;
   wire       wrClr   = wrEn && (offs == OFF_CLR_LO || offs == OFF_CLR_HI);
   wire       wrSet   = wrEn && (offs == OFF_SET_LO || offs == OFF_SET_HI);
   wire       wrFa    = wrEn && (offs == OFF_FA_LO || offs == OFF_FA_HI);
   wire       wrFb    = wrEn && (offs == OFF_FB_LO || offs == OFF_FB_HI);
   wire       hiSel   = offs[2] ^ offs[3] ? (offs == OFF_CLR_HI || offs == OFF_SET_HI ||
                                            offs == OFF_FA_HI || offs == OFF_FB_HI) :
                                            (offs == OFF_CLR_HI || offs == OFF_SET_HI ||
                                            offs == OFF_FA_HI || offs == OFF_FB_HI);
   wire       start   = wrMisc && pwdata[MISC_LAUNCH] && state_ff == ST_IDLE
                        && first_ff <= last_ff;

   wire [31:0] miscRd = {{(32-MISC_W){1'b0}}, misc_ff[MISC_W-1:1], launch_ff};
   wire [31:0] rdMux  =
      offs == OFF_MISC   ? miscRd :
      offs == OFF_RANGE  ? {3'h0, last_ff, 3'h0, first_ff} :
      offs == OFF_CLR_LO ? clr_ff[31:0] :
      offs == OFF_CLR_HI ? hiWord(clr_ff) :
      offs == OFF_SET_LO ? set_ff[31:0] :
      offs == OFF_SET_HI ? hiWord(set_ff) :
      offs == OFF_REQVAL ? {16'h0, reqVal_ff} :
      offs == OFF_VALMSK ? {16'h0, valMask_ff} :
      offs == OFF_BITMSK ? {16'h0, bitMask_ff} :
      offs == OFF_FA_LO  ? filtA_ff[31:0] :
      offs == OFF_FA_HI  ? hiWord(filtA_ff) :
      offs == OFF_FB_LO  ? filtB_ff[31:0] :
      offs == OFF_FB_HI  ? hiWord(filtB_ff) : RST_WORD;

   // apb answers one cycle after setup, with no wait states
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= RST_WORD;
      end else begin
         pready_ff  <= setup;
         pslverr_ff <= setup && !mapped;
         prdata_ff  <= (setup && !pwrite && mapped) ? rdMux : RST_WORD;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         misc_ff    <= '0;
         first_ff   <= '0;
         last_ff    <= '0;
         reqVal_ff  <= '0;
         valMask_ff <= '0;
         bitMask_ff <= '0;
      end else begin
         if (wrMisc)
            misc_ff <= {pwdata[MISC_W-1:1], 1'b0};
         if (wrRange) begin
            first_ff <= pwdata[ADDR_W-1:0];
            last_ff  <= pwdata[RANGE_LAST+ADDR_W-1:RANGE_LAST];
         end
         if (wrEn && offs == OFF_REQVAL)
            reqVal_ff <= pwdata[GRP_W-1:0];
         if (wrEn && offs == OFF_VALMSK)
            valMask_ff <= pwdata[GRP_W-1:0];
         if (wrEn && offs == OFF_BITMSK)
            bitMask_ff <= pwdata[GRP_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         clr_ff   <= RST_MASK;
         set_ff   <= RST_MASK;
         filtA_ff <= RST_MASK;
         filtB_ff <= RST_MASK;
      end else begin
         if (wrClr)
            clr_ff <= merge53(clr_ff, pwdata, hiSel);
         if (wrSet)
            set_ff <= merge53(set_ff, pwdata, hiSel);
         if (wrFa)
            filtA_ff <= merge53(filtA_ff, pwdata, hiSel);
         if (wrFb)
            filtB_ff <= merge53(filtB_ff, pwdata, hiSel);
      end
   end

   // ***********************************************
   // entry qualification and modification
   // ***********************************************
   wire tupeCfg_t cfg = '{valEna: misc_ff[MISC_VAL], bitEna: misc_ff[MISC_BIT],
                          aEna: misc_ff[MISC_FA], bEna: misc_ff[MISC_FB],
                          combEna: misc_ff[MISC_COMB], reqVal: reqVal_ff,
                          valMask: valMask_ff, bitMask: bitMask_ff, filtA: filtA_ff,
                          filtB: filtB_ff, clr: clr_ff, set: set_ff};

   tupe_match_modify u_match (
      .cfg       (cfg),
      .entry     (entry_ff),
      .qualifies (qualifies),
      .newPorts  (newPorts)
   );

   // ***********************************************
   // table walker
   // ***********************************************
   wire               lastAddr = addr_ff == last_ff;
   wire [ADDR_W-1:0]  addrInc  = addr_ff + 13'h1;
   wire               advance  = (state_ff == ST_EVAL && !qualifies) ||
                                 (state_ff == ST_WRITE && tabGnt);

   always_comb begin
      nxt_state  = state_ff;
      nxt_addr   = addr_ff;
      nxt_launch = launch_ff;
      nxt_entry  = entry_ff;
      nxt_req    = req_ff;
      case (state_ff)
         ST_IDLE: begin
            if (start) begin
               nxt_launch = 1'b1;
               nxt_addr   = first_ff;
               nxt_req    = '{req: 1'b1, we: 1'b0, addr: first_ff, wdata: '0};
               nxt_state  = ST_READ;
            end
         end
         ST_READ: begin
            if (tabGnt) begin
               nxt_req.req = 1'b0;
               nxt_state   = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (tabRvalid) begin
               nxt_entry = tabRdata;
               nxt_state = ST_EVAL;
            end
         end
         ST_EVAL: begin
            if (qualifies) begin
               nxt_req   = '{req: 1'b1, we: 1'b1, addr: addr_ff,
                             wdata: '{other: entry_ff.other, grp: entry_ff.grp,
                                      ports: newPorts}};
               nxt_state = ST_WRITE;
            end
         end
         ST_WRITE: begin
            if (tabGnt)
               nxt_req.req = 1'b0;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      if (advance) begin
         if (lastAddr) begin
            nxt_launch = 1'b0;
            nxt_state  = ST_IDLE;
         end else begin
            nxt_addr  = addrInc;
            nxt_req   = '{req: 1'b1, we: 1'b0, addr: addrInc, wdata: '0};
            nxt_state = ST_READ;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_ff  <= ST_IDLE;
         addr_ff   <= '0;
         launch_ff <= 1'b0;
         entry_ff  <= '0;
         req_ff    <= '0;
      end else begin
         state_ff  <= nxt_state;
         addr_ff   <= nxt_addr;
         launch_ff <= nxt_launch;
         entry_ff  <= nxt_entry;
         req_ff    <= nxt_req;
      end
   end

   assign tabReq  = req_ff;
   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;

   // ***********************************************
   // assertions
   // ***********************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   wire evalQ = state_ff == ST_EVAL && qualifies;

   launch_start_a:
      assert property (start |=> launch_ff && tabReq.req && !tabReq.we && tabReq.addr == $past(first_ff))
      else $error("walk did not start at first address");

   range_end_a:
      assert property ($fell(launch_ff) |-> $past(addr_ff) == $past(last_ff))
      else $error("walk ended before last address");

   value_match_a:
      assert property (state_ff == ST_EVAL && cfg.valEna &&
                       (entry_ff.grp & cfg.valMask) != cfg.reqVal |-> !qualifies)
      else $error("value mismatch qualified");

   bit_match_a:
      assert property (state_ff == ST_EVAL && cfg.bitEna && (entry_ff.grp & cfg.bitMask) == '0
                       |=> state_ff != ST_WRITE)
      else $error("group bit miss was written");

   filter_a_a:
      assert property (state_ff == ST_EVAL && cfg.aEna && (entry_ff.ports & cfg.filtA) == '0
                       |-> !qualifies)
      else $error("first filter miss qualified");

   filter_b_a:
      assert property (state_ff == ST_EVAL && cfg.bEna && (entry_ff.ports & cfg.filtB) == '0
                       |-> !qualifies)
      else $error("second filter miss qualified");

   comb_mode_a:
      assert property (state_ff == ST_EVAL && cfg.combEna && !cfg.valEna && !cfg.bitEna &&
                       !cfg.aEna && !cfg.bEna && (entry_ff.grp & cfg.bitMask) != '0 |-> qualifies)
      else $error("combined hit not qualified");

   all_off_a:
      assert property (state_ff == ST_EVAL && !cfg.valEna && !cfg.bitEna && !cfg.aEna &&
                       !cfg.bEna && !cfg.combEna |=> state_ff == ST_WRITE)
      else $error("unfiltered entry not written");

   toggle_bits_a:
      assert property (evalQ |=> (tabReq.wdata.ports & $past(clr_ff) & $past(set_ff)) ==
                       (~$past(entry_ff.ports) & $past(clr_ff) & $past(set_ff)))
      else $error("toggle ports wrong");

   clear_bits_a:
      assert property (evalQ |=> (tabReq.wdata.ports & $past(clr_ff) & ~$past(set_ff)) == '0)
      else $error("cleared ports not zero");

   set_keep_a:
      assert property (evalQ |=> (tabReq.wdata.ports & ~$past(clr_ff)) ==
                       (($past(entry_ff.ports) | $past(set_ff)) & ~$past(clr_ff)))
      else $error("set or kept ports wrong");

   write_back_a:
      assert property (evalQ |=> tabReq.req && tabReq.we && tabReq.addr == $past(addr_ff) &&
                       tabReq.wdata.grp == $past(entry_ff.grp))
      else $error("write back wrong");

   hold_req_a:
      assert property (tabReq.req && !tabGnt |=> tabReq.req && $stable(tabReq.addr) && $stable(tabReq.we))
      else $error("table request dropped before grant");

   write_other_a:
      assert property (evalQ |=> tabReq.wdata.other == $past(entry_ff.other))
      else $error("other entry fields changed on write back");

   ascend_order_a:
      assert property (advance && !lastAddr |=> tabReq.req && !tabReq.we &&
                       tabReq.addr == $past(addr_ff) + 13'h1)
      else $error("next read not at the following address");

   launch_hold_a:
      assert property (launch_ff && !(advance && lastAddr) |=> launch_ff)
      else $error("launch bit cleared before range end");

   empty_range_a:
      assert property (state_ff == ST_IDLE && wrMisc && first_ff > last_ff |=> !launch_ff && !tabReq.req)
      else $error("empty range started a walk");

endmodule : vlan_table_bulk_updater
`default_nettype wire

// >>> vlan_table_bulk_updater_test.sv
/*
 * self-checking bench of the vlan table bulk updater: apb tasks, a table responder and range walks.
 * assumes vlan_tupe_pkg and the design are compiled first; the bench stands in for the table arbiter.
 */
`timescale 1ns/100ps
`default_nettype none
module vlan_table_bulk_updater_test
   import vlan_tupe_pkg::*;
;
   logic        clk;
   logic        reset_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   tableReq_t   tabReq;
   logic        tabGnt;
   logic        tabRvalid;
   vlanEntry_t  tabRdata;
   tupeCfg_t    cfg;
   vlanEntry_t  ents [4];
   logic [4:0]  modes [7];
   logic [12:0] first;
   int          cmp_count;
   int          fail_count;

   vlan_table_bulk_updater dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tabReq(tabReq), .tabGnt(tabGnt), .tabRvalid(tabRvalid), .tabRdata(tabRdata));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ************
   // checking
   // ************
   task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check32

   task automatic check_ent(input string what, input vlanEntry_t exp, input vlanEntry_t got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check_ent

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude

   task automatic timed_out(input string what);
      fail_count++;
      $display("Error %s expected answer seen timeout", what);
      conclude();
   endtask : timed_out

   // ************
   // apb master
   // ************
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {24'h0, a};
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      // answer is read mid-cycle, where it has settled, and taken at the next rising edge
      do begin
         @(negedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) timed_out("pready");
      rd = prdata;
      err = pslverr;
      @(posedge clk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic expErr);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      check32(what, exp, r);
      check32("slave error", {31'h0, expErr}, {31'h0, e});
   endtask : rd_chk

   // ************
   // reference model
   // ************
   function automatic logic qual_of(input vlanEntry_t e);
      logic bitHit;
      logic aHit;
      bitHit = |(e.grp & cfg.bitMask);
      aHit = |(e.ports & cfg.filtA);
      return (!cfg.valEna || ((e.grp & cfg.valMask) == cfg.reqVal)) && (!cfg.bitEna || bitHit)
         && (!cfg.aEna || aHit) && (!cfg.bEna || |(e.ports & cfg.filtB)) && (!cfg.combEna || bitHit || aHit);
   endfunction : qual_of

   function automatic logic [31:0] img(input int i, input logic [12:0] f, input logic [12:0] l);
      case (i)
         0: return {26'h0, cfg.combEna, cfg.bEna, cfg.aEna, cfg.bitEna, cfg.valEna, 1'b0};
         1: return {3'h0, l, 3'h0, f};
         2: return cfg.clr[31:0];
         3: return {11'h0, cfg.clr[52:32]};
         4: return cfg.set[31:0];
         5: return {11'h0, cfg.set[52:32]};
         6: return {16'h0, cfg.reqVal};
         7: return {16'h0, cfg.valMask};
         8: return {16'h0, cfg.bitMask};
         9: return cfg.filtA[31:0];
         10: return {11'h0, cfg.filtA[52:32]};
         11: return cfg.filtB[31:0];
         default: return {11'h0, cfg.filtB[52:32]};
      endcase
   endfunction : img

   // ************
   // table responder
   // ************
   task automatic wait_req(output tableReq_t q);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (tabReq.req !== 1'b1 && n < 60);
      if (tabReq.req !== 1'b1) timed_out("table request");
      q = tabReq;
   endtask : wait_req

   task automatic serve(input logic [12:0] a, input vlanEntry_t e, input int lat);
      tableReq_t  q;
      vlanEntry_t x;
      x = e;
      x.ports = (e.ports & ~cfg.clr & ~cfg.set) | (cfg.set & ~cfg.clr) | (~e.ports & cfg.clr & cfg.set);
      wait_req(q);
      check32("read request", {18'h0, q.we, q.addr}, {18'h0, 1'b0, a});
      repeat (lat + 1) @(posedge clk);
      tabGnt <= 1'b1;
      @(posedge clk);
      tabGnt <= 1'b0;
      repeat (lat) @(posedge clk);
      tabRvalid <= 1'b1;
      tabRdata  <= e;
      @(posedge clk);
      tabRvalid <= 1'b0;
      tabRdata  <= ~e;
      if (qual_of(e)) begin
         wait_req(q);
         check32("write request", {18'h0, q.we, q.addr}, {18'h0, 1'b1, a});
         check_ent("written entry", x, q.wdata);
         @(posedge clk);
         tabGnt <= 1'b1;
         @(posedge clk);
         tabGnt <= 1'b0;
      end
   endtask : serve

   task automatic load_cfg(input logic [12:0] f, input logic [12:0] l);
      for (int i = 12; i >= 0; i--) wr(8'(4 * i), img(i, f, l));
      for (int i = 0; i <= 12; i++) rd_chk("register readback", 8'(4 * i), img(i, f, l), 1'b0);
   endtask : load_cfg

   task automatic idle_chk(input string what);
      logic [31:0] cnt;
      cnt = '0;
      repeat (12) begin
         @(posedge clk);
         if (tabReq.req !== 1'b0) cnt++;
      end
      check32(what, 32'h0, cnt);
   endtask : idle_chk

   // ************
   // main sequence
   // ************
   initial begin
      {psel, penable, pwrite, tabGnt, tabRvalid} = '0;
      paddr = '0;
      pwdata = '0;
      tabRdata = '0;
      reset_n = 1'b0;
      cmp_count = 0;
      fail_count = 0;
      cfg = '0;
      cfg.reqVal = 16'h0a00;
      cfg.valMask = 16'hff00;
      cfg.bitMask = 16'h00f0;
      cfg.filtA = 53'h10_0000_0000_0001;
      cfg.filtB = 53'h00_0000_0000_0100;
      cfg.clr = 53'h1f_0000_0000_0003;
      cfg.set = 53'h14_0000_0000_0005;
      ents[0] = '{other: 32'h1234_5678, grp: 16'h0a10, ports: 53'h10_0000_0000_000f};
      ents[1] = '{other: 32'h9abc_def0, grp: 16'h0b01, ports: 53'h10_0000_0000_0100};
      ents[2] = '{other: 32'h0f0f_a5a5, grp: 16'h0a80, ports: 53'h00_0000_ffff_0000};
      ents[3] = '{other: 32'hc3c3_3c3c, grp: 16'h0a01, ports: 53'h00_0000_0000_0200};
      modes = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h09};
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i <= 12; i++) rd_chk("reset value", 8'(4 * i), 32'h0, 1'b0);
      rd_chk("unmapped read", 8'h34, 32'h0, 1'b1);
      rd_chk("misaligned read", 8'h06, 32'h0, 1'b1);
      $display("reset and map test done");
      for (int m = 0; m < 7; m++) begin
         {cfg.combEna, cfg.bEna, cfg.aEna, cfg.bitEna, cfg.valEna} = modes[m];
         first = 13'h1ffc - 13'(4 * m);
         load_cfg(first, first + 13'd3);
         wr(OFF_MISC, img(0, first, first) | 32'h1);
         if (m == 0) rd_chk("busy launch", OFF_MISC, 32'h1, 1'b0);
         for (int k = 0; k < 4; k++) serve(first + 13'(k), ents[k], m % 3);
         idle_chk("requests after range");
         rd_chk("launch after walk", OFF_MISC, img(0, first, first), 1'b0);
         $display("walk test %0d done", m);
      end
      cfg = '0;
      load_cfg(13'h0010, 13'h000f);
      wr(OFF_MISC, 32'h1);
      idle_chk("requests for empty range");
      rd_chk("launch for empty range", OFF_MISC, 32'h0, 1'b0);
      $display("empty range test done");
      conclude();
   end
endmodule : vlan_table_bulk_updater_test
`default_nettype wire

// >>> vlan_tupe_pkg.sv
/*
 * constants, field layouts and carrier types of the vlan table bulk updater.
 * assumes one core clock; the vlan table and its arbiter sit outside the block.
 */
package vlan_tupe_pkg;

   localparam int PORTS   = 53;
   localparam int GRP_W   = 16;
   localparam int ADDR_W  = 13;
   localparam int OTHER_W = 32;
   localparam int HI_W    = PORTS - 32;

   // register byte offsets
   localparam logic [7:0] OFF_MISC   = 8'h00;
   localparam logic [7:0] OFF_RANGE  = 8'h04;
   localparam logic [7:0] OFF_CLR_LO = 8'h08;
   localparam logic [7:0] OFF_CLR_HI = 8'h0c;
   localparam logic [7:0] OFF_SET_LO = 8'h10;
   localparam logic [7:0] OFF_SET_HI = 8'h14;
   localparam logic [7:0] OFF_REQVAL = 8'h18;
   localparam logic [7:0] OFF_VALMSK = 8'h1c;
   localparam logic [7:0] OFF_BITMSK = 8'h20;
   localparam logic [7:0] OFF_FA_LO  = 8'h24;
   localparam logic [7:0] OFF_FA_HI  = 8'h28;
   localparam logic [7:0] OFF_FB_LO  = 8'h2c;
   localparam logic [7:0] OFF_FB_HI  = 8'h30;

   // control word and range word fields
   localparam int MISC_LAUNCH = 0;
   localparam int MISC_VAL    = 1;
   localparam int MISC_BIT    = 2;
   localparam int MISC_FA     = 3;
   localparam int MISC_FB     = 4;
   localparam int MISC_COMB   = 5;
   localparam int MISC_W      = 6;
   localparam int RANGE_LAST  = 16;

   localparam logic [31:0]    RST_WORD  = 32'h0;
   localparam logic [PORTS-1:0] RST_MASK = '0;

   typedef struct packed {
      logic [OTHER_W-1:0] other;
      logic [GRP_W-1:0]   grp;
      logic [PORTS-1:0]   ports;
   } vlanEntry_t;

   typedef struct packed {
      logic             valEna;
      logic             bitEna;
      logic             aEna;
      logic             bEna;
      logic             combEna;
      logic [GRP_W-1:0] reqVal;
      logic [GRP_W-1:0] valMask;
      logic [GRP_W-1:0] bitMask;
      logic [PORTS-1:0] filtA;
      logic [PORTS-1:0] filtB;
      logic [PORTS-1:0] clr;
      logic [PORTS-1:0] set;
   } tupeCfg_t;

   typedef struct packed {
      logic              req;
      logic              we;
      logic [ADDR_W-1:0] addr;
      vlanEntry_t        wdata;
   } tableReq_t;

endpackage : vlan_tupe_pkg
